/* src/acp_pkg.sv */
// Purpose: Shared constants for the converter clock prescaler
// Assumes: 100 MHz clk
// Notes: Conversion counts are in converter clock periods
package acp_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned NOMINAL_HZ = 500_000;
   localparam int unsigned OSC_HALF_CYCLES = CLK_HZ / (2 * NOMINAL_HZ);
   localparam int unsigned DIV_W = 3;
   localparam int unsigned STAGES = 7;
   localparam int unsigned SET_W = 4;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned OSC_W = 8;
   localparam int unsigned ACQ3_US = 508;
   localparam int unsigned ACQ3_TICKS = ACQ3_US * (NOMINAL_HZ / 1000) / 1000;
   localparam logic [CNT_W-1:0] ACQ_BASE3 = CNT_W'(ACQ3_TICKS);
   localparam logic [CNT_W-1:0] ACQ_BASE0 = ACQ_BASE3 >> 3;
   localparam logic [CNT_W-1:0] ACQ_BASE1 = ACQ_BASE3 >> 2;
   localparam logic [CNT_W-1:0] ACQ_BASE2 = ACQ_BASE3 >> 1;
   localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_HALF_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [SET_W-1:0] SET_AVG = 4'h8;

   typedef enum logic [1:0] {ACP_IDLE, ACP_BUS, ACP_SHUNT} acp_state_t;

   // Converter clock periods for one conversion setting
   function automatic logic [CNT_W-1:0] acp_ticks(input logic [SET_W-1:0] s);
      logic [CNT_W-1:0] r;
      r = ACQ_BASE3;
      if (s < SET_AVG) begin
         unique case (s[1:0])
            2'h0: r = ACQ_BASE0;
            2'h1: r = ACQ_BASE1;
            2'h2: r = ACQ_BASE2;
            2'h3: r = ACQ_BASE3;
         endcase
      end else begin
         r = ACQ_BASE3 << s[2:0];
      end
      return r;
   endfunction
endpackage

/* src/acp_div_if.sv */
// Purpose: Carrier between synchroniser and divider chain
// Assumes: One clock domain
// Notes: None
`timescale 1ns/10ps
interface acp_div_if;
   logic ext_level;
   logic ext_rise;
   logic [acp_pkg::DIV_W-1:0] div_sel;
   logic tap_level;
   modport top (output ext_level, output ext_rise, output div_sel,
                input tap_level);
   modport chain (input ext_level, input ext_rise, input div_sel,
                  output tap_level);
endinterface

/* src/acp_divider.sv */
// Purpose: Cascade of divide-by-2 stages on the external clock
// Assumes: Edges arrive already synchronised
// Notes: Each stage toggles when all lower stages are high
`timescale 1ns/10ps
module acp_divider (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Chain side
   acp_div_if.chain dif
);
   logic [acp_pkg::STAGES-1:0] stage_q;
   logic [acp_pkg::STAGES:0] carry;
   logic [acp_pkg::STAGES:0] taps;

   assign carry[0] = dif.ext_rise;
   assign taps[0] = dif.ext_level;

   genvar i;
   generate
      for (i = 0; i < acp_pkg::STAGES; i++) begin : g_stage
         assign carry[i+1] = carry[i] & stage_q[i];
         assign taps[i+1] = stage_q[i];
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               stage_q[i] <= 1'b0;
            end else if (carry[i]) begin
               stage_q[i] <= ~stage_q[i];
            end
         end
      end
   endgenerate

   // Tap chosen by divide field, divide by 2 to the power sel
   assign dif.tap_level = taps[dif.div_sel];
endmodule

/* src/acp_top.sv */
// Purpose: Converter clock source select, prescaler and conversion timer
// Assumes: 100 MHz clk; configuration inputs are synchronous to clk
// Notes: Converter clock is regenerated as a level plus a rising tick
//
// What this block does
// - Own oscillator yields a nominal 500 kHz system clock.
// - System clock is used directly as the converter sampling clock.
// - Acquisition times scale linearly with system clock period.
// - External pin enters through a Schmitt buffer into the first stage.
// - Divide-by-2 stage cascade; divide field selects the tap.
// - Bus and shunt conversion times are set independently.
// - Setting 3 takes 508 us at nominal clock, longer when slowed.
`timescale 1ns/10ps
module acp_top (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // External clock pin
   input wire logic ext_clock_or_irq_pin,
   // Configuration
   input wire logic use_external_clock,
   input wire logic [acp_pkg::DIV_W-1:0] clock_divide_select,
   input wire logic [acp_pkg::SET_W-1:0] bus_conversion_setting,
   input wire logic [acp_pkg::SET_W-1:0] shunt_conversion_setting,
   // Conversion control
   input wire logic convert_start,
   // Clock outputs
   output logic sys_clock,
   output logic sample_tick,
   output logic using_external,
   // Conversion status
   output logic busy,
   output logic bus_done,
   output logic shunt_done
);
   acp_div_if dif ();

   // Pin synchroniser, three stages
   logic [2:0] pin_sync_q;
   logic ext_level_q;
   logic ext_rise;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_sync_q <= 3'h0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], ext_clock_or_irq_pin};
      end
   end

   // Hysteresis: level changes only when stages two and three agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_level_q <= 1'b0;
      end else if (pin_sync_q[1] == pin_sync_q[2]) begin
         ext_level_q <= pin_sync_q[2];
      end
   end

   assign ext_rise = (pin_sync_q[1] == pin_sync_q[2]) & pin_sync_q[2] &
                     ~ext_level_q;

   assign dif.ext_level = ext_level_q;
   assign dif.ext_rise = ext_rise;
   assign dif.div_sel = clock_divide_select;

   acp_divider u_div (
      .clk(clk),
      .reset_n(reset_n),
      .dif(dif)
   );

   // Internal oscillator
   logic [acp_pkg::OSC_W-1:0] osc_cnt_q;
   logic osc_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_cnt_q <= '0;
         osc_q <= 1'b0;
      end else if (osc_cnt_q == acp_pkg::OSC_LAST) begin
         osc_cnt_q <= '0;
         osc_q <= ~osc_q;
      end else begin
         osc_cnt_q <= osc_cnt_q + 1'b1;
      end
   end

   // Source select: park low on the old source, leave on a low new one
   logic use_ext_q;
   logic park_q;
   logic cur_level;
   logic cand_level;
   logic sys_d;
   logic sys_q;
   logic tick_q;

   assign cur_level = use_ext_q ? dif.tap_level : osc_q;
   assign cand_level = use_external_clock ? dif.tap_level : osc_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         use_ext_q <= 1'b0;
         park_q <= 1'b0;
      end else if (!park_q) begin
         if (use_external_clock != use_ext_q && !cur_level) begin
            park_q <= 1'b1;
         end
      end else if (!cand_level) begin
         park_q <= 1'b0;
         use_ext_q <= use_external_clock;
      end
   end

   // Parked clock stays low, so neither source leaves a runt
   assign sys_d = park_q ? 1'b0 : cur_level;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         sys_q <= sys_d;
         tick_q <= sys_d & ~sys_q;
      end
   end

   // Conversion timer counted in converter clock periods
   acp_pkg::acp_state_t state_q;
   logic [acp_pkg::CNT_W-1:0] cnt_q;
   logic bus_done_q;
   logic shunt_done_q;
   logic last_tick;
   logic busy_q;
   logic [acp_pkg::SET_W-1:0] shunt_set_q;

   assign last_tick = tick_q && cnt_q == acp_pkg::CNT_ONE;

   // Shunt setting held from start, one request uses one pair of settings
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shunt_set_q <= '0;
      end else if (state_q == acp_pkg::ACP_IDLE && convert_start) begin
         shunt_set_q <= shunt_conversion_setting;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= acp_pkg::ACP_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            acp_pkg::ACP_IDLE: begin
               if (convert_start) begin
                  cnt_q <= acp_pkg::acp_ticks(bus_conversion_setting);
                  state_q <= acp_pkg::ACP_BUS;
               end
            end
            acp_pkg::ACP_BUS: begin
               if (last_tick) begin
                  cnt_q <= acp_pkg::acp_ticks(shunt_set_q);
                  state_q <= acp_pkg::ACP_SHUNT;
               end else if (tick_q) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            acp_pkg::ACP_SHUNT: begin
               if (last_tick) begin
                  cnt_q <= '0;
                  state_q <= acp_pkg::ACP_IDLE;
               end else if (tick_q) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: begin
               state_q <= acp_pkg::ACP_IDLE;
            end
         endcase
      end
   end

   // Busy flag registered from the phase that follows
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
      end else begin
         unique case (state_q)
            acp_pkg::ACP_IDLE: busy_q <= convert_start;
            acp_pkg::ACP_BUS: busy_q <= 1'b1;
            acp_pkg::ACP_SHUNT: busy_q <= !last_tick;
            default: busy_q <= 1'b0;
         endcase
      end
   end

   // Completion pulses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_done_q <= 1'b0;
         shunt_done_q <= 1'b0;
      end else begin
         bus_done_q <= last_tick && state_q == acp_pkg::ACP_BUS;
         shunt_done_q <= last_tick && state_q == acp_pkg::ACP_SHUNT;
      end
   end

   assign sys_clock = sys_q;
   assign sample_tick = tick_q;
   assign using_external = use_ext_q;
   assign busy = busy_q;
   assign bus_done = bus_done_q;
   assign shunt_done = shunt_done_q;
endmodule

/* bench/acp_props.sv */
// Purpose: Port checks for acp_top
// Assumes: 100 MHz clk
// Notes: Settings held through a conversion
`timescale 1ns/10ps
module acp_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Inputs
   input wire logic [acp_pkg::SET_W-1:0] bus_conversion_setting,
   input wire logic [acp_pkg::SET_W-1:0] shunt_conversion_setting,
   input wire logic convert_start,
   // Outputs
   input wire logic sys_clock,
   input wire logic sample_tick,
   input wire logic using_external,
   input wire logic busy,
   input wire logic bus_done,
   input wire logic shunt_done
);
   logic [15:0] tk_q;
   logic [15:0] hc_q;
   logic seen_q;
   function automatic logic [15:0] n_of(input logic [3:0] s);
      return s[3] ? 16'h00FE << s[2:0] : 16'h00FE >> (2'h3 - s[1:0]);
   endfunction
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) tk_q <= 16'h0000;
      else if ((convert_start && !busy) || bus_done) tk_q <= 16'h0000;
      else if (sample_tick) tk_q <= tk_q + 16'h0001;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) hc_q <= 16'h0000;
      else if ($changed(sys_clock)) hc_q <= 16'h0000;
      else hc_q <= hc_q + 16'h0001;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) seen_q <= 1'b0;
      else if ($changed(using_external)) seen_q <= 1'b0;
      else if ($changed(sys_clock)) seen_q <= 1'b1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_tick_at_rise: assert property (sample_tick == $rose(sys_clock))
      else $error("tick not aligned to clock rise");
   a_tick_single: assert property (sample_tick |=> !sample_tick)
      else $error("tick longer than one cycle");
   a_osc_half: assert property (seen_q && !using_external &&
      $changed(sys_clock) |-> hc_q == 16'(acp_pkg::OSC_HALF_CYCLES - 1))
      else $error("oscillator half period wrong");
   a_start_busy: assert property (convert_start && !busy |=> busy)
      else $error("start not taken");
   a_bus_count: assert property (bus_done |->
      tk_q == n_of(bus_conversion_setting))
      else $error("bus conversion length wrong");
   a_shunt_count: assert property (shunt_done |->
      tk_q == n_of(shunt_conversion_setting))
      else $error("shunt conversion length wrong");
   a_busy_end: assert property ($fell(busy) |-> shunt_done)
      else $error("busy dropped without shunt done");
   a_bus_first: assert property (bus_done |-> busy)
      else $error("bus done outside conversion");
   a_swap_low: assert property ($changed(using_external) |-> !sys_clock)
      else $error("source swapped while clock high");
endmodule
bind acp_top acp_props u_props (.clk, .reset_n, .bus_conversion_setting,
   .shunt_conversion_setting, .convert_start, .sys_clock, .sample_tick,
   .using_external, .busy, .bus_done, .shunt_done);

/* bench/acp_ext_src.sv */
// Purpose: External clock source on the pin
// Assumes: Runs only while enabled, low otherwise
// Notes: Start offset keeps pin edges off clk edges
`timescale 1ns/10ps
module acp_ext_src #(parameter real HALF_NS = 125.0) (
   // Control
   input wire logic en,
   // Pin
   output logic pin
);
   initial pin = 1'b0;
   always begin
      if (en) begin
         #(HALF_NS) pin = ~pin;
      end else begin
         pin = 1'b0;
         @(posedge en);
         #3.0;
      end
   end
endmodule

/* bench/adc_clock_prescaler_tb.sv */
// Purpose: Self-checking bench for acp_top
// Assumes: 100 MHz clk, 4 MHz pin source
// Notes: Random settings from a fixed seed
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module adc_clock_prescaler_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic en = 1'b0;
   logic use_ext = 1'b0;
   logic start = 1'b0;
   logic pin, sys_clock, sample_tick, using_external, busy, bus_done;
   logic shunt_done;
   logic [acp_pkg::DIV_W-1:0] div = 3'h3;
   logic [acp_pkg::SET_W-1:0] bs = 4'h0;
   logic [acp_pkg::SET_W-1:0] ss = 4'h0;
   logic [31:0] seed = 32'h0000_5601;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   acp_ext_src u_src (.en(en), .pin(pin));
   acp_top dut (.clk(clk), .reset_n(reset_n), .ext_clock_or_irq_pin(pin),
      .use_external_clock(use_ext), .clock_divide_select(div),
      .bus_conversion_setting(bs), .shunt_conversion_setting(ss),
      .convert_start(start), .sys_clock(sys_clock),
      .sample_tick(sample_tick), .using_external(using_external),
      .busy(busy), .bus_done(bus_done), .shunt_done(shunt_done));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic [15:0] exp_n(input logic [3:0] s);
      return s[3] ? 16'h00FE << s[2:0] : 16'h00FE >> (2'h3 - s[1:0]);
   endfunction
   function automatic logic [15:0] exp_per(input logic [2:0] d, logic x);
      return x ? 16'h0019 << d : 16'(2 * acp_pkg::OSC_HALF_CYCLES);
   endfunction
   task automatic test_done;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic gap(output logic [15:0] n);
      n = 16'h0000;
      do @(negedge clk); while (sample_tick !== 1'b1);
      do begin
         @(negedge clk);
         n++;
      end while (sample_tick !== 1'b1);
   endtask
   task automatic period(input logic [2:0] d, input logic x);
      logic [15:0] n;
      @(posedge clk);
      div <= d;
      use_ext <= x;
      if (x) en <= 1'b1;
      repeat (3) gap(n);
      `CHK(n, exp_per(d, x))
      `CHK(using_external, x)
      // Source stops only once the handover away from it is done
      if (!x) en <= 1'b0;
   endtask
   task automatic convert(input logic [3:0] b, input logic [3:0] s);
      logic [15:0] k;
      do @(negedge clk); while (sample_tick !== 1'b1);
      @(posedge clk);
      bs <= b;
      ss <= s;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      k = 16'h0000;
      do begin
         @(negedge clk);
         if (sample_tick === 1'b1) k++;
      end while (bus_done !== 1'b1);
      `CHK(k, exp_n(b))
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      k = 16'h0000;
      do begin
         @(negedge clk);
         if (sample_tick === 1'b1) k++;
      end while (shunt_done !== 1'b1);
      `CHK(k, exp_n(s))
      `CHK(busy, 1'b0)
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 96000) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      period(3'h3, 1'b0);
      seed = xs(seed);
      convert(4'h3, seed[7:4] & 4'h4);
      period(3'h3, 1'b1);
      period(3'h4, 1'b1);
      seed = xs(seed);
      convert(seed[3:0] & 4'h4, seed[7:4] & 4'h4);
      period(3'h4, 1'b0);
      test_done;
   end
endmodule
